// *** verilog/msp_pkg.sv ***
/*
 package of the serial register port: slave address, register indices,
 field positions, reset values, host command layout, bus timing, states.
 assumes a 50 MHz aclk on both ends.
*/
`default_nettype none
package msp_pkg;
	////////////////////////////////////////////////////////////////////
	// bus address and device register map
	localparam logic [5:0] ADDR_HI = 6'h13; // upper six address bits
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_VIDEO = 8'h01;
	localparam logic [7:0] REG_DISP = 8'h02;
	localparam logic [7:0] REG_SYSPD = 8'h1A;
	localparam int BIT_WLOCK = 4;
	localparam int BIT_BLANK = 5;
	localparam int BIT_SLEEP = 5;
	localparam logic [7:0] RST_VIDEO = 8'h03;
	localparam logic [7:0] RST_DISP = 8'h20;
	localparam logic [7:0] RST_SYSPD = 8'h00;
	localparam logic RST_WLOCK = 1'b0;
	////////////////////////////////////////////////////////////////////
	// host controller registers on AXI4-Lite
	localparam logic [7:0] HOST_CMD = 8'h00;
	localparam logic [7:0] HOST_STS = 8'h04;
	localparam int CMD_IDX_LSB = 0;
	localparam int CMD_DAT_LSB = 8;
	localparam int CMD_OP_LSB = 16;
	localparam int CMD_HOLD = 18;
	localparam int CMD_SEL = 19;
	localparam int STS_BUSY = 0;
	localparam int STS_NACK = 1;
	localparam int STS_RD_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	////////////////////////////////////////////////////////////////////
	// timing: quarter of the fastest legal bus clock period
	localparam int CLK_NS = 20;
	localparam int SCL_QTR_NS = 625;
	localparam int QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
	////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_READ = 2'b01,
		OP_CONT_WR = 2'b10,
		OP_CONT_RD = 2'b11
	} msp_op_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_INDEX = 3'b010,
		S_WDATA = 3'b011,
		S_RDATA = 3'b100
	} msp_dev_st_t;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_NEXT = 3'b001,
		H_START = 3'b010,
		H_BYTE = 3'b011,
		H_STOP = 3'b100
	} msp_host_st_t;
	typedef enum logic [2:0] {
		K_START = 3'b000,
		K_TX = 3'b001,
		K_RX = 3'b010,
		K_STOP = 3'b011,
		K_DONE = 3'b100
	} msp_item_t;
endpackage : msp_pkg
`default_nettype wire

// *** verilog/msp_i2c_if.sv ***
/*
 two-wire bus between host and device ends.
 assumes open-drain pins with pull-ups; an enable high pulls the line.
*/
`timescale 1ns/1ns
`default_nettype none
interface msp_i2c_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// wired-and of all drivers, pull-up otherwise
	assign scl = host_scl_oe ? host_scl_o : 1'b1;
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
	modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
		output host_sda_oe, input scl, input sda);
	modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface : msp_i2c_if
`default_nettype wire

// *** verilog/msp_dev.sv ***
/*
 device end: two-wire slave with the display control registers.
 assumes scl/sda synchronous to aclk and far slower than it.
*/
`timescale 1ns/1ns
`default_nettype none
module msp_dev
	import msp_pkg::*;
#(
	parameter logic [2:0] REV_ID = 3'h0 // arbitrary value
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic address_select_pin,
	input wire logic reset_n_pin,
	input wire logic burn_in_pin,
	msp_i2c_if.dev bus,
	output logic display_on,
	output logic global_sleep,
	output logic [7:0] video_input_config,
	output logic [7:0] display_control
);
	////////////////////////////////////////////////////////////////////
	// line sampling and bus events
	logic scl_q;
	logic sda_q;
	logic sel_r;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	// previous line levels, idle-high after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sel_r <= 1'b0;
		end else begin
			scl_q <= bus.scl;
			sda_q <= bus.sda;
			sel_r <= address_select_pin;
		end
	end

	// sequencing keys off scl edges and off sda edges while scl is high, no video timing needed
	assign scl_rise = bus.scl & ~scl_q;
	assign scl_fall = ~bus.scl & scl_q;
	assign start_ev = bus.scl & scl_q & sda_q & ~bus.sda;
	assign stop_ev = bus.scl & scl_q & ~sda_q & bus.sda;

	////////////////////////////////////////////////////////////////////
	// register file
	logic wlock_r;
	logic [7:0] video_r;
	logic [7:0] disp_r;
	logic [7:0] syspd_r;
	logic [7:0] rd_val;
	logic wr_stb;
	msp_dev_st_t st_r;
	logic [3:0] bc_r;
	logic [7:0] sh_r;
	logic [7:0] idx_r;
	logic drv_r;
	logic rd_r;
	logic mack_r;
	logic addr_hit;

	// read mux; holes read as zero
	always_comb begin
		case (idx_r)
			REG_STATUS: rd_val = {3'h0, wlock_r, 1'b0, REV_ID};
			REG_VIDEO: rd_val = video_r;
			REG_DISP: rd_val = disp_r;
			REG_SYSPD: rd_val = syspd_r;
			default: rd_val = 8'h00;
		endcase
	end

	// write strobe at the end of the eighth data bit
	assign wr_stb = scl_fall && (bc_r == 4'h7) && (st_r == S_WDATA) && reset_n_pin;

	// stores; the lock bit itself stays writable so it can be lifted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wlock_r <= RST_WLOCK;
			video_r <= RST_VIDEO;
			disp_r <= RST_DISP;
			syspd_r <= RST_SYSPD;
		end else if (wr_stb) begin
			if (idx_r == REG_STATUS) begin
				wlock_r <= sh_r[BIT_WLOCK];
			end else if (!wlock_r) begin
				case (idx_r)
					REG_VIDEO: video_r <= sh_r;
					REG_DISP: disp_r <= sh_r;
					REG_SYSPD: syspd_r <= sh_r;
					default: ;
				endcase
			end
		end
	end

	// display enable; burn-in mode overrides the blank bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			display_on <= 1'b0;
			global_sleep <= 1'b0;
		end else begin
			display_on <= burn_in_pin | ~disp_r[BIT_BLANK];
			// sleep gates only the core; this port and the stores keep running
			global_sleep <= syspd_r[BIT_SLEEP];
		end
	end

	assign video_input_config = video_r;
	assign display_control = disp_r;

	////////////////////////////////////////////////////////////////////
	// slave byte engine
	assign addr_hit = (sh_r[7:1] == {ADDR_HI, sel_r});

	// only sda is ever pulled; scl is input only
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = drv_r;

	// bit counter 0..7 data, 8 the acknowledge slot, F waits out the start's scl fall
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= S_IDLE;
			bc_r <= 4'h0;
			sh_r <= 8'h00;
			idx_r <= 8'h00;
			drv_r <= 1'b0;
			rd_r <= 1'b0;
			mack_r <= 1'b0;
		end else if (start_ev) begin
			// repeated start lands here too, index is kept
			st_r <= S_ADDR;
			bc_r <= 4'hF;
			drv_r <= 1'b0;
		end else if (stop_ev) begin
			st_r <= S_IDLE;
			drv_r <= 1'b0;
		end else if (st_r != S_IDLE) begin
			if (scl_rise) begin
				if (bc_r != 4'h8 && st_r != S_RDATA) begin
					sh_r <= {sh_r[6:0], bus.sda};
				end
				if (bc_r == 4'h8) begin
					mack_r <= ~bus.sda;
				end
			end
			if (scl_fall) begin
				if (bc_r == 4'hF) begin
					// the fall closing a start carries no bit
					bc_r <= 4'h0;
				end else if (bc_r < 4'h7) begin
					bc_r <= bc_r + 4'h1;
					if (st_r == S_RDATA) begin
						sh_r <= {sh_r[6:0], 1'b0};
						drv_r <= ~sh_r[6];
					end
				end else if (bc_r == 4'h7) begin
					bc_r <= 4'h8;
					case (st_r)
						S_ADDR: begin
							if (addr_hit) begin
								drv_r <= 1'b1;
								rd_r <= sh_r[0];
							end else begin
								st_r <= S_IDLE;
							end
						end
						S_INDEX: begin
							idx_r <= sh_r;
							drv_r <= 1'b1;
						end
						S_WDATA: begin
							idx_r <= idx_r + 8'h01;
							drv_r <= 1'b1;
						end
						S_RDATA: drv_r <= 1'b0;
						default: st_r <= S_IDLE;
					endcase
				end else begin
					bc_r <= 4'h0;
					case (st_r)
						S_ADDR: begin
							if (rd_r) begin
								st_r <= S_RDATA;
								sh_r <= rd_val;
								drv_r <= ~rd_val[7];
								idx_r <= idx_r + 8'h01;
							end else begin
								st_r <= S_INDEX;
								drv_r <= 1'b0;
							end
						end
						S_INDEX: begin
							st_r <= S_WDATA;
							drv_r <= 1'b0;
						end
						S_WDATA: drv_r <= 1'b0;
						S_RDATA: begin
							if (mack_r) begin
								sh_r <= rd_val;
								drv_r <= ~rd_val[7];
								idx_r <= idx_r + 8'h01;
							end else begin
								st_r <= S_IDLE;
								drv_r <= 1'b0;
							end
						end
						default: st_r <= S_IDLE;
					endcase
				end
			end
		end
	end
endmodule : msp_dev
`default_nettype wire

// *** verilog/msp_host.sv ***
/*
 host end: AXI4-Lite command registers driving a two-wire bus master.
 assumes one slave on the bus that never stretches the clock.
*/
`timescale 1ns/1ns
`default_nettype none
module msp_host
	import msp_pkg::*;
#(
	parameter int QTR = QTR_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	msp_i2c_if.host bus
);
	if (QTR < 2) begin : g_chk
		$error("QTR must be at least 2");
	end
	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic aw_have_r;
	logic w_have_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go;
	logic cmd_go;
	msp_host_st_t hs_r;
	logic nack_r;
	logic [7:0] rx_r;

	// address and data are taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_have_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_have_r <= 1'b0;
		end else if (!aw_have_r && !s_axi_awready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_have_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_have_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_have_r <= 1'b0;
		end else if (!w_have_r && !s_axi_wready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// a command is refused while busy or with partial strobes
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	assign cmd_go = wr_go && (aw_addr_r == HOST_CMD) && (w_strb_r == 4'hF) && (hs_r == H_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= cmd_go ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// reads answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
			if (s_axi_araddr == HOST_STS) begin
				s_axi_rdata[STS_BUSY] <= (hs_r != H_IDLE);
				s_axi_rdata[STS_NACK] <= nack_r;
				s_axi_rdata[STS_RD_LSB +: 8] <= rx_r;
			end else if (s_axi_araddr != HOST_CMD) begin
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid && !s_axi_arready) begin
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// bus master sequencer
	msp_op_t op_r;
	msp_item_t item_k;
	logic [7:0] item_b;
	logic hold_r;
	logic sel_r;
	logic [7:0] idx_r;
	logic [7:0] dat_r;
	logic [2:0] step_r;
	logic [1:0] q_r;
	logic [15:0] tick_r;
	logic q_adv;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [7:0] rxsh_r;
	logic tx_r;
	logic badack_r;
	logic scl_oe_r;
	logic sda_oe_r;

	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_scl_oe = scl_oe_r;
	assign bus.host_sda_oe = sda_oe_r;

	// step list of each operation
	always_comb begin
		item_k = hold_r ? K_DONE : K_STOP;
		item_b = {ADDR_HI, sel_r, 1'b0};
		case (op_r)
			OP_WRITE: begin
				if (step_r == 3'h0) item_k = K_START;
				if (step_r == 3'h1) item_k = K_TX;
				if (step_r == 3'h2) begin item_k = K_TX; item_b = idx_r; end
				if (step_r == 3'h3) begin item_k = K_TX; item_b = dat_r; end
			end
			OP_READ: begin
				if (step_r == 3'h0 || step_r == 3'h3) item_k = K_START;
				if (step_r == 3'h1) item_k = K_TX;
				if (step_r == 3'h2) begin item_k = K_TX; item_b = idx_r; end
				if (step_r == 3'h4) begin item_k = K_TX; item_b[0] = 1'b1; end
				if (step_r == 3'h5) item_k = K_RX;
			end
			OP_CONT_WR: begin
				if (step_r == 3'h0) begin item_k = K_TX; item_b = dat_r; end
			end
			default: begin
				if (step_r == 3'h0) item_k = K_RX;
			end
		endcase
	end

	// quarter-period tick keeps scl at or below the bus limit
	assign q_adv = (tick_r == 16'(QTR - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn || hs_r == H_IDLE || hs_r == H_NEXT || q_adv) begin
			tick_r <= 16'h0000;
		end else begin
			tick_r <= tick_r + 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs_r <= H_IDLE;
			op_r <= OP_WRITE;
			hold_r <= 1'b0;
			sel_r <= 1'b0;
			idx_r <= 8'h00;
			dat_r <= 8'h00;
			step_r <= 3'h0;
			q_r <= 2'h0;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			rxsh_r <= 8'h00;
			rx_r <= 8'h00;
			tx_r <= 1'b0;
			badack_r <= 1'b0;
			nack_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else begin
			case (hs_r)
				H_IDLE: begin
					if (cmd_go) begin
						op_r <= msp_op_t'(w_data_r[CMD_OP_LSB +: 2]);
						hold_r <= w_data_r[CMD_HOLD];
						sel_r <= w_data_r[CMD_SEL];
						idx_r <= w_data_r[CMD_IDX_LSB +: 8];
						dat_r <= w_data_r[CMD_DAT_LSB +: 8];
						step_r <= 3'h0;
						nack_r <= 1'b0;
						hs_r <= H_NEXT;
					end
				end
				H_NEXT: begin
					q_r <= 2'h0;
					bit_r <= 4'h0;
					badack_r <= 1'b0;
					sda_oe_r <= 1'b0; // let go after an ack we drove
					sh_r <= item_b;
					tx_r <= (item_k == K_TX);
					case (item_k)
						K_START: hs_r <= H_START;
						K_TX, K_RX: hs_r <= H_BYTE;
						K_STOP: hs_r <= H_STOP;
						default: hs_r <= H_IDLE;
					endcase
				end
				H_START: begin
					if (q_adv) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: sda_oe_r <= 1'b0;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b1;
							default: begin
								scl_oe_r <= 1'b1;
								step_r <= step_r + 3'h1;
								hs_r <= H_NEXT;
							end
						endcase
					end
				end
				H_BYTE: begin
					if (q_adv) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: begin
								if (bit_r == 4'h8) begin
									// ack more read data only when holding the bus
									sda_oe_r <= !tx_r && hold_r;
								end else begin
									sda_oe_r <= tx_r && !sh_r[7];
								end
							end
							2'h1: scl_oe_r <= 1'b0;
							2'h2: begin
								if (bit_r != 4'h8) begin
									rxsh_r <= {rxsh_r[6:0], bus.sda};
								end else if (tx_r) begin
									badack_r <= bus.sda;
								end
							end
							default: begin
								scl_oe_r <= 1'b1;
								sh_r <= {sh_r[6:0], 1'b0};
								bit_r <= bit_r + 4'h1;
								if (bit_r == 4'h8) begin
									step_r <= step_r + 3'h1;
									if (!tx_r) begin
										rx_r <= rxsh_r;
									end
									if (tx_r && badack_r) begin
										nack_r <= 1'b1;
										hs_r <= H_STOP;
									end else begin
										hs_r <= H_NEXT;
									end
								end
							end
						endcase
					end
				end
				H_STOP: begin
					if (q_adv) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: sda_oe_r <= 1'b1;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b0;
							default: hs_r <= H_IDLE;
						endcase
					end
				end
				default: hs_r <= H_IDLE;
			endcase
		end
	end
endmodule : msp_host
`default_nettype wire

// *** verif/msp_assertions.sv ***
/*
 checker of the two-wire bus that joins the host and device ends.
 assumes QTR equals the host instance's quarter and aclk drives both ends.
*/
`timescale 1ns/1ns
`default_nettype none
module msp_assertions #(
	parameter int QTR = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic scl_q_r;
	logic sda_q_r;
	logic busy_r;
	logic [15:0] run_r;
	logic [15:0] dev_run_r;
	// last levels and length of the running scl level, saturating
	always_ff @(posedge aclk) begin
		scl_q_r <= !aresetn | scl;
		sda_q_r <= !aresetn | sda;
		if (!aresetn || scl != scl_q_r) begin
			run_r <= 16'h0001;
		end else if (run_r != 16'hFFFF) begin
			run_r <= run_r + 16'h0001;
		end
	end
	// frame state from start and stop, seen as sda edges while scl is high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_r <= 1'b0;
		end else if (scl && scl_q_r && sda_q_r && !sda) begin
			busy_r <= 1'b1;
		end else if (scl && scl_q_r && !sda_q_r && sda) begin
			busy_r <= 1'b0;
		end
	end
	// how long the device has held sda down without a break
	always_ff @(posedge aclk) begin
		if (!aresetn || !dev_sda_oe) begin
			dev_run_r <= 16'h0000;
		end else if (dev_run_r != 16'hFFFF) begin
			dev_run_r <= dev_run_r + 16'h0001;
		end
	end
	////////////////////////////////////////
	scl_host_only_a: assert property (scl == !host_scl_oe && !dev_sda_o)
		else $error("bus clock moved without the host");
	pins_low_only_a: assert property (!host_scl_o && !host_sda_o)
		else $error("open-drain pin drives a high level");
	dev_hold_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("device changed sda while scl high");
	start_by_host_a: assert property (scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
		else $error("start or stop not made by host");
	reset_release_a: assert property (disable iff (1'b0) !aresetn |=> !dev_sda_oe && !host_sda_oe && !host_scl_oe)
		else $error("bus not released in reset");
	scl_high_len_a: assert property (scl_q_r && !scl |-> run_r >= 16'(2 * QTR - 1))
		else $error("scl high phase too short");
	scl_low_len_a: assert property (!scl_q_r && scl |-> run_r >= 16'(2 * QTR - 1))
		else $error("scl low phase too short");
	idle_quiet_a: assert property (!busy_r |-> !dev_sda_oe)
		else $error("device drives sda outside a frame");
	dev_release_a: assert property (dev_sda_oe |-> dev_run_r <= 16'(36 * QTR + 4))
		else $error("device holds sda past a byte");
	cover property ($rose(busy_r));
	cover property ($rose(dev_sda_oe));
	cover property ($fell(busy_r));
endmodule : msp_assertions
`default_nettype wire

// *** verif/microdisplay_serial_register_port_tb_top.sv ***
/*
 bench of the serial register port: host and device ends face each other.
 assumes the host quarter shortened to QTR and a 50 MHz aclk.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("Error %s exp %0h got %0h", nm, e, g); end end
module microdisplay_serial_register_port_tb_top
	import msp_pkg::*;
	;
	localparam int QTR = 4;
	localparam int LIM = 4000;
	logic aclk, aresetn, sel, rnp, bip, awvalid, wvalid, bready, arvalid, rready, nk;
	logic awready, wready, bvalid, arready, rvalid, display_on, global_sleep;
	logic [7:0] awaddr, araddr, video_input_config, display_control, v, d0, d1;
	logic [31:0] wdata, rdata, s;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [7:0] shd [0:255];
	logic [7:0] tbl [0:3];
	int checks, fails;
	////////////////////////////////////////
	msp_i2c_if u_msp_i2c_if ();
	msp_host #(.QTR(QTR)) u_msp_host (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .bus(u_msp_i2c_if));
	msp_dev u_msp_dev (.aclk(aclk), .aresetn(aresetn), .address_select_pin(sel),
		.reset_n_pin(rnp), .burn_in_pin(bip), .bus(u_msp_i2c_if),
		.display_on(display_on), .global_sleep(global_sleep),
		.video_input_config(video_input_config), .display_control(display_control));
	msp_assertions #(.QTR(QTR)) u_msp_assertions (.aclk(aclk), .aresetn(aresetn),
		.host_scl_o(u_msp_i2c_if.host_scl_o), .host_scl_oe(u_msp_i2c_if.host_scl_oe),
		.host_sda_o(u_msp_i2c_if.host_sda_o), .host_sda_oe(u_msp_i2c_if.host_sda_oe),
		.dev_sda_o(u_msp_i2c_if.dev_sda_o), .dev_sda_oe(u_msp_i2c_if.dev_sda_oe),
		.scl(u_msp_i2c_if.scl), .sda(u_msp_i2c_if.sda));
	// free-running 50 MHz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	////////////////////////////////////////
	// expected register content after a bus write: reset pin and lock gate it
	function automatic logic [7:0] nxt(logic [7:0] i, logic [7:0] d, logic [7:0] o);
		if (!rnp || (shd[0][BIT_WLOCK] && i != REG_STATUS)) return o;
		if (i == REG_STATUS) return {o[7:5], d[BIT_WLOCK], o[3:0]};
		return d;
	endfunction : nxt
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic tmo(input int n);
		if (n >= LIM) begin
			fails++;
			$display("Error wait exp done got timeout");
			report_and_stop();
		end
	endtask : tmo
	// one write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
			output logic [1:0] rr);
		bit aw;
		bit w;
		int n;
		aw = 1'b0;
		w = 1'b0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w) && n < LIM) begin
			@(posedge aclk);
			n++;
			if (!aw && awready) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!bvalid && n < LIM);
		rr = bresp;
		bready <= 1'b0;
		tmo(n);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!arready && n < LIM);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!rvalid && n < LIM);
		d = rdata;
		rr = rresp;
		rready <= 1'b0;
		tmo(n);
	endtask : axi_rd
	task automatic wait_idle(output logic [31:0] st);
		logic [1:0] rr;
		int n;
		n = 0;
		do begin
			axi_rd(HOST_STS, st, rr);
			n++;
		end while (st[STS_BUSY] !== 1'b0 && n < LIM);
		tmo(n);
	endtask : wait_idle
	task automatic cmd(input logic [1:0] op, input logic [7:0] i, input logic [7:0] d,
			input logic h, input logic sl, output logic [7:0] rd, output logic nak);
		logic [1:0] rr;
		logic [31:0] st;
		axi_wr(HOST_CMD, {12'h000, sl, h, op, d, i}, 4'hF, rr);
		`CHK("bresp", RESP_OKAY, rr)
		wait_idle(st);
		rd = st[STS_RD_LSB +: 8];
		nak = st[STS_NACK];
	endtask : cmd
	task automatic chk_ports();
		repeat (3) @(posedge aclk);
		`CHK("video", shd[REG_VIDEO], video_input_config)
		`CHK("disp", shd[REG_DISP], display_control)
		`CHK("on", bip | ~shd[REG_DISP][BIT_BLANK], display_on)
		`CHK("sleep", shd[REG_SYSPD][BIT_SLEEP], global_sleep)
	endtask : chk_ports
	task automatic wrx(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] rd;
		logic nak;
		cmd(OP_WRITE, i, d, 1'b0, sel, rd, nak);
		`CHK("wr ack", 1'b0, nak)
		if (i inside {REG_STATUS, REG_VIDEO, REG_DISP, REG_SYSPD}) shd[i] = nxt(i, d, shd[i]);
		chk_ports();
	endtask : wrx
	task automatic rdx(input logic [7:0] i);
		logic [7:0] rd;
		logic [7:0] m;
		logic nak;
		m = (i == REG_STATUS) ? 8'h17 : 8'hFF;
		cmd(OP_READ, i, 8'h00, 1'b0, sel, rd, nak);
		`CHK("rd ack", 1'b0, nak)
		`CHK("rd data", shd[i] & m, rd & m)
	endtask : rdx
	////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(42));
		{tbl[0], tbl[1], tbl[2], tbl[3]} = {REG_VIDEO, REG_DISP, 8'h30, REG_STATUS};
		foreach (shd[k]) shd[k] = 8'h00;
		shd[REG_VIDEO] = RST_VIDEO;
		shd[REG_DISP] = RST_DISP;
		shd[REG_SYSPD] = RST_SYSPD;
		{checks, fails} = 64'h0;
		{aresetn, sel, rnp, bip, awvalid, wvalid, bready, arvalid, rready} = 9'h040;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk_ports();
		rdx(REG_DISP);
		$display("test defaults done");
		axi_rd(8'h08, s, r);
		`CHK("unmapped resp", RESP_SLVERR, r)
		axi_wr(HOST_CMD, {12'h000, sel, 1'b0, OP_WRITE, 8'h5A, REG_VIDEO}, 4'hF, r);
		axi_wr(HOST_CMD, {12'h000, sel, 1'b0, OP_WRITE, 8'hA5, REG_VIDEO}, 4'hF, r);
		`CHK("busy resp", RESP_SLVERR, r)
		wait_idle(s);
		shd[REG_VIDEO] = 8'h5A;
		chk_ports();
		$display("test host refusals done");
		for (int k = 0; k < 8; k++) begin
			sel <= k[0];
			@(posedge aclk);
			wrx(tbl[k % 4], 8'($urandom));
			rdx(tbl[k % 4]);
		end
		wrx(REG_STATUS, 8'h00);
		cmd(OP_WRITE, REG_VIDEO, ~shd[REG_VIDEO], 1'b0, ~sel, v, nk);
		`CHK("foreign nack", 1'b1, nk)
		chk_ports();
		$display("test random and select done");
		wrx(REG_DISP, 8'h00);
		wrx(REG_DISP, 8'h20);
		bip <= 1'b1;
		chk_ports();
		bip <= 1'b0;
		$display("test blank done");
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		cmd(OP_WRITE, REG_VIDEO, d0, 1'b1, sel, v, nk);
		cmd(OP_CONT_WR, 8'h00, d1, 1'b0, sel, v, nk);
		{shd[REG_VIDEO], shd[REG_DISP]} = {d0, d1};
		chk_ports();
		cmd(OP_READ, REG_VIDEO, 8'h00, 1'b1, sel, v, nk);
		`CHK("seq rd0", d0, v)
		cmd(OP_CONT_RD, 8'h00, 8'h00, 1'b0, sel, v, nk);
		`CHK("seq rd1", d1, v)
		$display("test sequential done");
		rnp <= 1'b0;
		@(posedge aclk);
		wrx(REG_VIDEO, ~shd[REG_VIDEO]);
		rnp <= 1'b1;
		wrx(REG_STATUS, 8'h10);
		wrx(REG_VIDEO, ~shd[REG_VIDEO]);
		rdx(REG_STATUS);
		wrx(REG_STATUS, 8'h00);
		$display("test gating done");
		wrx(REG_SYSPD, 8'h20);
		rdx(REG_VIDEO);
		wrx(REG_SYSPD, 8'h00);
		$display("test sleep done");
		report_and_stop();
	end
endmodule : microdisplay_serial_register_port_tb_top
`default_nettype wire
